// ==== rtl/hps_switch.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "hps_regs.svh"

module hps_switch #(
  parameter int SETTLE_CYCLES = `HPS_SETTLE_CYCLES,
  parameter int UNPLUG_CYCLES = `HPS_UNPLUG_CYCLES,
  parameter int TIMER_WIDTH   = 24
) (
  input  wire logic            i_clock,
  input  wire logic            i_arst_n,
  input  wire hps_pkg::hps_in_t i_ctrl,
  output var hps_pkg::hps_out_t o_ctrl
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SINGLE,
    ST_DUAL,
    ST_SETTLE,
    ST_EMULATE
  } hps_state_t;

  //////////////////////////////////////////////////////////////////////////

  // Counts must fit the timers and keep the pause shorter than the unplug
  initial
  begin
    if (TIMER_WIDTH < 2 || TIMER_WIDTH > 32)
      $error("hps_switch: TIMER_WIDTH out of range");
    if (SETTLE_CYCLES >= UNPLUG_CYCLES)
      $error("hps_switch: settle pause not shorter than unplug time");
    if (SETTLE_CYCLES < 2 || UNPLUG_CYCLES < 2)
      $error("hps_switch: timer counts too small");
    if (longint'(UNPLUG_CYCLES) >= (longint'(1) << TIMER_WIDTH))
      $error("hps_switch: TIMER_WIDTH too small for unplug time");
    if (longint'(SETTLE_CYCLES) >= (longint'(1) << TIMER_WIDTH))
      $error("hps_switch: TIMER_WIDTH too small for settle pause");
  end

  // Presence level of the port that sel_b names
  function automatic logic pres_of(input logic sel_b,
                                   input hps_pkg::hps_in_t in);
    pres_of = sel_b ? in.sink_b_presence_in : in.sink_a_presence_in;
  endfunction

  function automatic logic connected_of(input hps_state_t st);
    connected_of = (st == ST_SINGLE) || (st == ST_DUAL);
  endfunction


  //////////////////////////////////////////////////////////////////////////

  hps_state_t state;
  hps_state_t next_state;
  logic       sel_b;
  logic       next_sel_b;
  logic       prio_seen;
  logic       powered;
  logic       next_powered;
  logic       pres_out;
  logic       next_pres_out;
  logic       both;
  logic       none;
  logic       sel_pres;
  logic       oth_pres;
  logic       prio_pres;
  logic       prio_change;
  logic       sel_is_prio;

  logic             ld_settle;
  logic             stop_settle;
  logic             settle_done;
  logic             settle_run;
  logic             ld_unplug;
  logic             stop_unplug;
  logic             unplug_done;
  logic             unplug_run;
  logic             ld_lowwatch;
  logic             stop_lowwatch;
  logic             lowwatch_done;
  logic             lowwatch_run;
  logic             connected;

  assign both        = i_ctrl.sink_a_presence_in && i_ctrl.sink_b_presence_in;
  assign none        = !i_ctrl.sink_a_presence_in
                       && !i_ctrl.sink_b_presence_in;
  assign sel_pres    = pres_of(sel_b, i_ctrl);
  assign oth_pres    = pres_of(!sel_b, i_ctrl);
  assign prio_pres   = pres_of(i_ctrl.prio_b, i_ctrl);
  assign sel_is_prio = (sel_b == i_ctrl.prio_b);
  assign prio_change = (i_ctrl.prio_b != prio_seen);

  //////////////////////////////////////////////////////////////////////////
  // Three timers: settle pause, forced-low emulation, selected-low watch

  hps_timer #(.WIDTH(TIMER_WIDTH)) u_settle (
    .i_clock   (i_clock),
    .i_arst_n  (i_arst_n),
    .i_load    (ld_settle),
    .i_stop    (stop_settle),
    .i_count   (TIMER_WIDTH'(SETTLE_CYCLES)),
    .o_running (settle_run),
    .o_done    (settle_done)
  );

  hps_timer #(.WIDTH(TIMER_WIDTH)) u_unplug (
    .i_clock   (i_clock),
    .i_arst_n  (i_arst_n),
    .i_load    (ld_unplug),
    .i_stop    (stop_unplug),
    .i_count   (TIMER_WIDTH'(UNPLUG_CYCLES)),
    .o_running (unplug_run),
    .o_done    (unplug_done)
  );

  hps_timer #(.WIDTH(TIMER_WIDTH)) u_lowwatch (
    .i_clock   (i_clock),
    .i_arst_n  (i_arst_n),
    .i_load    (ld_lowwatch),
    .i_stop    (stop_lowwatch),
    .i_count   (TIMER_WIDTH'(UNPLUG_CYCLES)),
    .o_running (lowwatch_run),
    .o_done    (lowwatch_done)
  );

  // Low-watch runs while the selected sink is low in a connected state
  assign connected     = connected_of(state);
  assign ld_lowwatch   = connected && !sel_pres && !lowwatch_run;
  assign stop_lowwatch = sel_pres || !connected;

  //////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    next_state    = state;
    next_sel_b    = sel_b;
    next_powered  = powered;
    next_pres_out = sel_pres;
    ld_settle     = 1'b0;
    stop_settle   = 1'b0;
    ld_unplug     = 1'b0;
    stop_unplug   = 1'b0;
    case (state)
      ST_IDLE:
      begin
        next_pres_out = 1'b0;
        next_powered  = 1'b0;
        if (both)
        begin
          next_state    = ST_DUAL;
          next_sel_b    = i_ctrl.prio_b;
          next_powered  = i_ctrl.power_down_allow_n;
          next_pres_out = 1'b1;
        end
        else if (!none)
        begin
          next_state    = ST_SINGLE;
          next_sel_b    = i_ctrl.sink_b_presence_in;
          next_powered  = i_ctrl.power_down_allow_n;
          next_pres_out = 1'b1;
        end
      end
      ST_SINGLE:
      begin
        next_powered = i_ctrl.power_down_allow_n;
        // Pulses repeat one edge late, so 100 ns pulses survive
        next_pres_out = sel_pres;
        if (lowwatch_done)
        begin
          if (oth_pres)
          begin
            next_state = ST_SINGLE;
            next_sel_b = !sel_b;
          end
          else
          begin
            next_state    = ST_IDLE;
            next_powered  = 1'b0;
            next_pres_out = 1'b0;
          end
        end
        else if (oth_pres && sel_pres)
        begin
          if (sel_is_prio)
            next_state = ST_DUAL;
          else
          begin
            next_state    = ST_EMULATE;
            ld_unplug     = 1'b1;
            next_pres_out = 1'b0;
          end
        end
      end
      ST_DUAL:
      begin
        next_powered  = i_ctrl.power_down_allow_n;
        next_pres_out = sel_pres;
        if (lowwatch_done)
        begin
          // Selected sink gone for the full unplug time
          if (oth_pres)
          begin
            next_state = ST_SINGLE;
            next_sel_b = !sel_b;
          end
          else
          begin
            next_state    = ST_IDLE;
            next_powered  = 1'b0;
            next_pres_out = 1'b0;
          end
        end
        else if (!oth_pres)
          next_state = ST_SINGLE;
        else if (prio_change)
        begin
          next_state = ST_SETTLE;
          ld_settle  = 1'b1;
        end
      end
      ST_SETTLE:
      begin
        next_pres_out = sel_pres;
        next_powered  = i_ctrl.power_down_allow_n;
        // Both sinks gone mid-pause: nothing left to choose
        if (none)
        begin
          next_state    = ST_IDLE;
          next_powered  = 1'b0;
          next_pres_out = 1'b0;
          stop_settle   = 1'b1;
        end
        else if (!both)
        begin
          next_state  = ST_SINGLE;
          stop_settle = 1'b1;
          if (!sel_pres)
            next_sel_b = !sel_b;
        end
        else if (settle_done)
        begin
          if (sel_is_prio)
            next_state = ST_DUAL;
          else
          begin
            next_state    = ST_EMULATE;
            ld_unplug     = 1'b1;
            next_pres_out = 1'b0;
          end
        end
      end
      ST_EMULATE:
      begin
        next_pres_out = 1'b0;
        next_powered  = i_ctrl.power_down_allow_n;
        // Restart on a priority dropout keeps the forced low whole
        if (!prio_pres)
        begin
          if (sel_b != i_ctrl.prio_b && !sel_pres)
          begin
            if (none)
            begin
              next_state   = ST_IDLE;
              next_powered = 1'b0;
            end
            else
              next_state = ST_SINGLE;
            next_sel_b  = i_ctrl.prio_b;
            stop_unplug = 1'b1;
          end
          else
            ld_unplug = 1'b1;
        end
        else if (unplug_done)
        begin
          next_state    = both ? ST_DUAL : ST_SINGLE;
          next_sel_b    = i_ctrl.prio_b;
          next_pres_out = 1'b1;
        end
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Priority level is tracked only once the change has been acted on,
  // so a glitch shorter than the pause leaves no trace

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state     <= ST_IDLE;
      sel_b     <= `HPS_RST_SEL_B;
      powered   <= 1'b0;
      pres_out  <= `HPS_RST_PRES_OUT;
      prio_seen <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      sel_b    <= next_sel_b;
      powered  <= next_powered;
      pres_out <= next_pres_out;
      if (next_state != ST_SETTLE)
        prio_seen <= i_ctrl.prio_b;
    end
  end

  assign o_ctrl.sel_b           = sel_b;
  assign o_ctrl.link_enable     = powered;
  assign o_ctrl.presence_out    = pres_out;
  assign o_ctrl.presence_out_en = (state != ST_IDLE);

endmodule

`default_nettype wire

// ==== rtl/hps_regs.svh ====
`ifndef HPS_REGS_SVH
`define HPS_REGS_SVH

// Clock rate in kHz (20 MHz)
`define HPS_CLK_KHZ          20000
// Settle pause: 2 ms least, 4.7 ms most; aim at 3 ms
`define HPS_SETTLE_PAUSE_US  3000
// Unplug emulation: 170 ms least, 400 ms most; aim at 200 ms
`define HPS_UNPLUG_TIME_US   200000
// Cycles derived from the times above
`define HPS_SETTLE_CYCLES    ((`HPS_SETTLE_PAUSE_US * `HPS_CLK_KHZ) / 1000)
`define HPS_UNPLUG_CYCLES    ((`HPS_UNPLUG_TIME_US * `HPS_CLK_KHZ) / 1000)
// Least low pulse reproduced, in ns, and in cycles at 50 ns period
`define HPS_MIN_PULSE_NS     100
`define HPS_MIN_PULSE_CYCLES ((`HPS_MIN_PULSE_NS * `HPS_CLK_KHZ + 999999) / 1000000)
// Reset values
`define HPS_RST_SEL_B        1'b0
`define HPS_RST_PRES_OUT     1'b0

`endif

// ==== rtl/hps_pkg.sv ====
package hps_pkg;

  typedef enum logic [1:0] {
    HPS_PORT_NONE,
    HPS_PORT_A,
    HPS_PORT_B
  } hps_port_t;

  typedef struct packed {
    logic sink_a_presence_in;
    logic sink_b_presence_in;
    logic prio_b;
    logic power_down_allow_n;
  } hps_in_t;

  typedef struct packed {
    logic sel_b;
    logic link_enable;
    logic presence_out;
    logic presence_out_en;
  } hps_out_t;

endpackage

// ==== rtl/hps_timer.sv ====
`timescale 1ns/1ns
`default_nettype none

// Down counter: load starts or restarts, done pulses once at expiry
module hps_timer #(
  parameter int WIDTH = 24
) (
  input  wire logic             i_clock,
  input  wire logic             i_arst_n,
  input  wire logic             i_load,
  input  wire logic             i_stop,
  input  wire logic [WIDTH-1:0] i_count,
  output logic                  o_running,
  output logic                  o_done
);

  logic [WIDTH-1:0] count;
  logic             next_done;

  initial
  begin
    if (WIDTH < 2)
      $error("hps_timer: WIDTH too small");
  end

  assign next_done = o_running && !i_load && !i_stop
                     && (count == WIDTH'(1));

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      count     <= '0;
      o_running <= 1'b0;
      o_done    <= 1'b0;
    end
    else
    begin
      o_done <= next_done;
      if (i_load)
      begin
        count     <= i_count;
        o_running <= 1'b1;
      end
      else if (i_stop || next_done)
      begin
        count     <= '0;
        o_running <= 1'b0;
      end
      else if (o_running)
        count <= count - WIDTH'(1);
    end
  end

endmodule

`default_nettype wire

// ==== dv/hps_switch_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module hps_switch_monitor #(
  parameter int SETTLE_CYCLES = 20,
  parameter int UNPLUG_CYCLES = 200
) (
  input wire logic              i_clock,
  input wire logic              i_arst_n,
  input wire hps_pkg::hps_in_t  i_ctrl,
  input wire hps_pkg::hps_out_t o_ctrl
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);
  wire logic a  = i_ctrl.sink_a_presence_in;
  wire logic b  = i_ctrl.sink_b_presence_in;
  wire logic p  = i_ctrl.prio_b;
  wire logic l  = i_ctrl.power_down_allow_n;
  wire logic en = o_ctrl.presence_out_en;
  wire logic q  = o_ctrl.presence_out;
  wire logic s  = o_ctrl.sel_b;
  wire logic pp = p ? b : a;
  int        low_run;
  // Forced low is the only way q sits low while both sinks are up
  always_ff @(posedge i_clock or negedge i_arst_n)
    if (!i_arst_n)
      low_run <= 0;
    else
      low_run <= (en && !q && a && b) ? low_run + 1 : 0;
  AST_IDLE_OFF: assert property (!en |-> !o_ctrl.link_enable)
    else $error("link on while idle");
  AST_WAKE_ON: assert property (!en && a && !b && l |=>
    en && o_ctrl.link_enable && !s && q) else $error("bad wake");
  AST_WAKE_LP: assert property (!en && a && !b && !l |=>
    en && !o_ctrl.link_enable && !s && q) else $error("bad low wake");
  AST_WAKE_B: assert property (!en && b && !a |=> en && s && q)
    else $error("bad wake on b");
  AST_FOLLOW: assert property (en && s && !a && !$past(a) |=>
    q == $past(b)) else $error("presence not repeated");
  AST_NO_LOW_SEL: assert property (en && $changed(s) |->
    (s ? $past(b) : $past(a))) else $error("absent port chosen");
  AST_PRIO_HOLD: assert property (en && s == p && pp |=> $stable(s))
    else $error("left priority port");
  AST_FORCE_LOW: assert property (en && s != p && a && b && $rose(pp)
    |=> !q [*8]) else $error("no unplug emulation");
  AST_SETTLE: assert property (en && a && b && q && $changed(p)
    |=> q [*8]) else $error("no settle pause");
  AST_LOW_MAX: assert property (low_run <= UNPLUG_CYCLES + 4)
    else $error("forced low too long");
  AST_LOW_MIN: assert property ($rose(q) && low_run > 2 |->
    low_run >= UNPLUG_CYCLES - 1) else $error("forced low too short");
  cover property (!en ##1 en);
  cover property (en && $changed(s));
  cover property ($rose(q) && low_run > 2);
endmodule
bind hps_switch hps_switch_monitor #(
  .SETTLE_CYCLES(SETTLE_CYCLES),
  .UNPLUG_CYCLES(UNPLUG_CYCLES)
) u_hps_switch_monitor (
  .i_clock (i_clock),
  .i_arst_n(i_arst_n),
  .i_ctrl  (i_ctrl),
  .o_ctrl  (o_ctrl)
);
`default_nettype wire

// ==== dv/hps_sink_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// Two sinks; each presence line is a driven level, never left floating
module hps_sink_model (
  output logic o_a,
  output logic o_b
);
  initial
  begin
    o_a = 1'b0;
    o_b = 1'b0;
  end
  task automatic set_sinks(input logic a, input logic b);
    o_a = a;
    o_b = b;
  endtask
endmodule
`default_nettype wire

// ==== dv/hps_switch_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module hps_switch_tb;
  localparam int SC = 20;
  localparam int UC = 200;
  logic              i_clock;
  logic              i_arst_n;
  logic              prio;
  logic              allow_n;
  wire logic         sa;
  wire logic         sb;
  hps_pkg::hps_in_t  i_ctrl;
  hps_pkg::hps_out_t o_ctrl;
  int                mismatches;
  int                check_count;
  int                n;
  // Inputs {a,b,prio,allow_n} then outputs {sel,link,pres,en}
  logic [7:0]        rows [7] = '{8'h97, 8'hb7, 8'h5f, 8'h83,
                                  8'h6b, 8'hff, 8'hd7};
  assign i_ctrl = {sa, sb, prio, allow_n};
  hps_sink_model u_hps_sink_model (.o_a(sa), .o_b(sb));
  hps_switch #(.SETTLE_CYCLES(SC), .UNPLUG_CYCLES(UC)) u_hps_switch (
    .i_clock (i_clock),
    .i_arst_n(i_arst_n),
    .i_ctrl  (i_ctrl),
    .o_ctrl  (o_ctrl)
  );
  initial
  begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (mismatches == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [3:0] exp, input logic [3:0] m);
    check_count++;
    if ((o_ctrl & m) !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, o_ctrl, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    check_count++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, got, lo);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge i_clock);
    #1;
  endtask
  task automatic drv(input logic [3:0] v);
    tick(1);
    u_hps_sink_model.set_sinks(v[3], v[2]);
    prio = v[1];
    allow_n = v[0];
  endtask
  task automatic rst(input int k);
    drv(4'h0);
    i_arst_n = 1'b0;
    tick(k);
    chk(4'h0, 4'hf);
    i_arst_n = 1'b1;
  endtask
  // Waits are bounded so a stuck switch ends the run instead of hanging
  task automatic wait_out(input logic [3:0] exp, input logic [3:0] m,
                          input int lim, output int k);
    k = 0;
    while ((o_ctrl & m) !== exp && k < lim)
    begin
      tick(1);
      k++;
    end
    if (k == lim)
    begin
      mismatches++;
      wrap_up();
    end
    else
      chk(exp, m);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mismatches = 0;
    check_count = 0;
    prio = 1'b0;
    allow_n = 1'b1;
    i_arst_n = 1'b0;
    rst(10);
    foreach (rows[r])
    begin
      drv(rows[r][7:4]);
      tick(1);
      chk(rows[r][3:0], 4'hf);
      rst(2);
    end
    drv(4'h5);
    drv(4'h1);
    tick(1);
    chk(4'hd, 4'hf);
    drv(4'h5);
    tick(1);
    chk(4'hf, 4'hf);
    drv(4'h1);
    wait_out(4'h0, 4'h7, UC + 10, n);
    chk_rng(n, UC - 1, UC + 4);
    drv(4'h5);
    tick(1);
    chk(4'hf, 4'hf);
    drv(4'hd);
    tick(1);
    chk(4'hd, 4'hf);
    tick(100);
    drv(4'h5);
    drv(4'hd);
    wait_out(4'h7, 4'hf, UC + 10, n);
    chk_rng(n, UC - 2, UC + 4);
    drv(4'h9);
    tick(20);
    drv(4'hd);
    tick(5);
    chk(4'h7, 4'hf);
    drv(4'hf);
    tick(5);
    drv(4'hd);
    tick(SC + 10);
    chk(4'h7, 4'hf);
    drv(4'hf);
    tick(SC - 5);
    chk(4'h7, 4'hf);
    wait_out(4'h5, 4'hf, 30, n);
    chk_rng(n + SC - 5, SC - 1, SC + 4);
    wait_out(4'hf, 4'hf, UC + 10, n);
    chk_rng(n, UC - 2, UC + 4);
    drv(4'hb);
    wait_out(4'h7, 4'hf, UC + 10, n);
    chk_rng(n, UC - 1, UC + 4);
    drv(4'h9);
    tick(SC + 10);
    chk(4'h7, 4'hf);
    wrap_up();
  end
endmodule
`default_nettype wire
